// ==== hw/nvb_params.svh ====
// Register addresses, field positions, reset values and timing counts
`ifndef NVB_PARAMS_SVH
`define NVB_PARAMS_SVH
// ==========================================================
// Register addresses in the special function area
`define NVB_ADDR_NV_ADDRESS  8'h3e
`define NVB_ADDR_NV_DATA     8'h3f
`define NVB_ADDR_NV_CONTROL  8'h40
`define NVB_ADDR_POINTER2    8'h03
`define NVB_ADDR_BANK_SEL    8'h04
`define NVB_ADDR_IND_PORT2   8'h02
// ==========================================================
// Control field positions
`define NVB_BIT_READ_START   0
`define NVB_BIT_READ_PERM    1
`define NVB_BIT_WRITE_START  2
`define NVB_BIT_WRITE_PERM   3
// ==========================================================
// Reset values and bank codes
`define NVB_RST_NV_ADDRESS   6'h00
`define NVB_RST_NV_DATA      8'h00
`define NVB_RST_NV_CONTROL   4'h0
`define NVB_RST_BANK_SEL     2'h0
`define NVB_BANK_CONTROL     2'h1
// ==========================================================
// Timing in system clock cycles
`define NVB_WRITE_CYCLES     4000
`define NVB_READ_CYCLES      4
`endif

// ==== hw/nvb_pkg.sv ====
// Types shared by the store access controller
package nvb_pkg;
  typedef enum logic [1:0] {
    NVB_BANK0,
    NVB_BANK1,
    NVB_BANK2,
    NVB_BANK_RSVD
  } nvb_bank_type;

  typedef enum {
    NVB_IDLE,
    NVB_READING,
    NVB_WRITING
  } nvb_state_type;

  // Processor register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvb_req_type;
endpackage

// ==== hw/nvb_timer.sv ====
// Self-timed delay counter for store write and read cycles
module nvb_timer
  import nvb_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  // Control
  input  wire logic             start_in,
  input  wire logic [WIDTH-1:0] count_in,
  output logic                  done_out
);
  // Refuse widths too narrow to count a cycle
  if (WIDTH < 2) begin
    $error("nvb_timer: WIDTH too small");
  end

  logic [WIDTH-1:0] remain;
  logic             running;

  // ==========================================================
  // Countdown; done pulses on the last cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      remain  <= '0;
      running <= 1'b0;
    end else if (start_in) begin
      remain  <= count_in;
      running <= 1'b1;
    end else if (running) begin
      remain <= remain - 1'b1;
      if (remain == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        running <= 1'b0;
      end
    end
  end

  assign done_out = running && (remain == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule

// ==== hw/nvb_ctrl.sv ====
// Byte access controller for the 64 x 8 non-volatile data store
// Operation
// - Store holds 64 bytes, 00H-3FH, outside normal data memory.
// - Each read or write moves one byte via address, data, control.
// - Address register: bits 5..0 writable, 7..6 read zero, reset 0.
// - Data register: 8-bit read/write, resets to zero.
// - Address, data direct in bank 0; control 40H bank 1 indirect.
// - Bank code 00 bank 0, 01 bank 1, 10 bank 2, 11 reserved.
// - Write permission bit 3 must be set; otherwise writes blocked.
// - Write start bit 2 launches write; hardware clears it at end.
// - Write start ignored unless permission was set beforehand.
// - Read permission bit 1 must be set; otherwise reads blocked.
// - Control bits 7..4 read zero; four bits reset to zero.
// - Read start bit 0 starts read, self-clears, byte held.
// - Write end sets done flag and multi-function request flag.
`include "nvb_params.svh"
module nvb_ctrl
  import nvb_pkg::*;
#(
  parameter int WRITE_CYCLES = `NVB_WRITE_CYCLES,
  parameter int READ_CYCLES  = `NVB_READ_CYCLES,
  parameter int DEPTH        = 64
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // Processor special register port
  input  nvb_req_type     req_in,
  output logic [7:0]      rdata_out,
  // Interrupt flags
  input  wire logic       done_flag_clr_in,
  output logic            store_write_done_flag_out,
  output logic            mf_request_out,
  input  wire logic       mf_request_clr_in
);
  localparam int TW = 16;
  // Refuse values the 16-bit timer or array cannot serve
  if (DEPTH != 64) begin
    $error("nvb_ctrl: store depth must be 64");
  end
  if (WRITE_CYCLES < 2 || WRITE_CYCLES > 65535) begin
    $error("nvb_ctrl: WRITE_CYCLES out of range");
  end
  if (READ_CYCLES < 2 || READ_CYCLES > 255) begin
    $error("nvb_ctrl: READ_CYCLES out of range");
  end

  // ==========================================================
  // Registers
  logic [5:0]    nv_address;
  logic [7:0]    nv_data;
  logic [3:0]    nv_control;
  logic [7:0]    second_indirect_pointer;
  nvb_bank_type  bank_selector;
  nvb_state_type state;
  logic [7:0]    store_mem [DEPTH];
  logic          timer_start;
  logic [TW-1:0] timer_count;
  logic          timer_done;

  // Decoded accesses
  logic ctl_hit;
  logic wr_addr;
  logic wr_data;
  logic wr_ctl;
  logic [3:0] ctl_w;
  logic start_write;
  logic start_read;

  // control only via indirect port with pointer 40H, bank 1
  // only bank code 01 reaches the control register
  assign ctl_hit = (req_in.addr == `NVB_ADDR_IND_PORT2)
                && (second_indirect_pointer == `NVB_ADDR_NV_CONTROL)
                && (bank_selector == NVB_BANK1);
  assign wr_addr = req_in.wr && (req_in.addr == `NVB_ADDR_NV_ADDRESS);
  assign wr_data = req_in.wr && (req_in.addr == `NVB_ADDR_NV_DATA);
  assign wr_ctl  = req_in.wr && ctl_hit;
  assign ctl_w   = req_in.wdata[3:0];

  // permission must already be set in the register
  assign start_write = wr_ctl && (state == NVB_IDLE)
                    && ctl_w[`NVB_BIT_WRITE_START]
                    && nv_control[`NVB_BIT_WRITE_PERM];
  // read start needs permission already held
  assign start_read  = wr_ctl && (state == NVB_IDLE) && !start_write
                    && ctl_w[`NVB_BIT_READ_START]
                    && nv_control[`NVB_BIT_READ_PERM];

  // ==========================================================
  // Pointer and bank selector
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      second_indirect_pointer <= 8'h00;
      bank_selector           <= nvb_bank_type'(`NVB_RST_BANK_SEL);
    end else if (req_in.wr) begin
      if (req_in.addr == `NVB_ADDR_POINTER2) begin
        second_indirect_pointer <= req_in.wdata;
      end
      if (req_in.addr == `NVB_ADDR_BANK_SEL) begin
        bank_selector <= nvb_bank_type'(req_in.wdata[1:0]);
      end
    end
  end

  // ==========================================================
  // Address register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      nv_address <= `NVB_RST_NV_ADDRESS;
    end else if (wr_addr) begin
      nv_address <= req_in.wdata[5:0];
    end
  end

  // ==========================================================
  // Data register; a finished read overrides a late CPU write
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      nv_data <= `NVB_RST_NV_DATA;
    end else if (state == NVB_READING && timer_done) begin
      // fetched byte held until next access
      nv_data <= store_mem[nv_address];
    end else if (wr_data) begin
      nv_data <= req_in.wdata;
    end
  end

  // ==========================================================
  // Store array write at cycle end; no reset on purpose
  always_ff @(posedge sys_clk_in) begin
    if (state == NVB_WRITING && timer_done) begin
      store_mem[nv_address] <= nv_data;
    end
  end

  // ==========================================================
  // Control register and cycle state
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      nv_control <= `NVB_RST_NV_CONTROL;
      state      <= NVB_IDLE;
    end else begin
      if (wr_ctl) begin
        nv_control[`NVB_BIT_WRITE_PERM] <= ctl_w[`NVB_BIT_WRITE_PERM];
        nv_control[`NVB_BIT_READ_PERM]  <= ctl_w[`NVB_BIT_READ_PERM];
      end
      unique case (state)
        NVB_IDLE: begin
          // no permission, start bit stays clear
          if (start_write) begin
            nv_control[`NVB_BIT_WRITE_START] <= 1'b1;
            state <= NVB_WRITING;
          end else if (start_read) begin
            nv_control[`NVB_BIT_READ_START] <= 1'b1;
            state <= NVB_READING;
          end
        end
        NVB_WRITING: begin
          if (timer_done) begin
            nv_control[`NVB_BIT_WRITE_START] <= 1'b0;
            state <= NVB_IDLE;
          end
        end
        NVB_READING: begin
          if (timer_done) begin
            nv_control[`NVB_BIT_READ_START] <= 1'b0;
            state <= NVB_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Write-done and multi-function flags; set wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      store_write_done_flag_out <= 1'b0;
      mf_request_out            <= 1'b0;
    end else begin
      // both flags raised at write end
      if (state == NVB_WRITING && timer_done) begin
        store_write_done_flag_out <= 1'b1;
        mf_request_out            <= 1'b1;
      end else begin
        if (done_flag_clr_in) store_write_done_flag_out <= 1'b0;
        if (mf_request_clr_in) mf_request_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Cycle timer
  // write length is loaded into the self-timed counter through count_in at start
  assign timer_start = start_write || start_read;
  assign timer_count = start_write ? TW'(WRITE_CYCLES) : TW'(READ_CYCLES);

  nvb_timer #(
    .WIDTH (TW)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (timer_start),
    .count_in   (timer_count),
    .done_out   (timer_done)
  );

  // ==========================================================
  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
    end else if (req_in.rd) begin
      if (req_in.addr == `NVB_ADDR_NV_ADDRESS) begin
        rdata_out <= {2'b00, nv_address};
      end else if (req_in.addr == `NVB_ADDR_NV_DATA) begin
        rdata_out <= nv_data;
      end else if (ctl_hit) begin
        rdata_out <= {4'h0, nv_control};
      end else if (req_in.addr == `NVB_ADDR_POINTER2) begin
        rdata_out <= second_indirect_pointer;
      end else if (req_in.addr == `NVB_ADDR_BANK_SEL) begin
        rdata_out <= {6'h00, bank_selector};
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end
endmodule

// ==== bench/nvb_ctrl_asserts.sv ====
// Port-level checks for the store access controller
module nvb_ctrl_asserts
  import nvb_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  // Register port
  input nvb_req_type     req_in,
  input wire logic [7:0] rdata_out,
  // Flags
  input wire logic       done_flag_clr_in,
  input wire logic       store_write_done_flag_out,
  input wire logic       mf_request_out,
  input wire logic       mf_request_clr_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  rdata_hold_a:
    assert property (!req_in.rd |=> $stable(rdata_out))
    else $error("read data moved without a read");
  addr_mask_a:
    assert property (req_in.wr && req_in.addr == 8'h3e ##1
      req_in.rd && req_in.addr == 8'h3e |=> rdata_out[7:6] == 2'h0
      && rdata_out[5:0] == $past(req_in.wdata[5:0], 2))
    else $error("address register readback wrong");
  data_rw_a:
    assert property (req_in.wr && req_in.addr == 8'h3f ##1
      req_in.rd && req_in.addr == 8'h3f
      |=> rdata_out == $past(req_in.wdata, 2))
    else $error("data register readback wrong");
  ctrl_upper_a:
    assert property (req_in.rd && req_in.addr == 8'h02
      |=> rdata_out[7:4] == 4'h0)
    else $error("control upper bits not zero");
  unmapped_a:
    assert property (req_in.rd && !(req_in.addr inside
      {8'h02, 8'h03, 8'h04, 8'h3e, 8'h3f}) |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  flag_hold_a:
    assert property (store_write_done_flag_out && !done_flag_clr_in
      |=> store_write_done_flag_out)
    else $error("done flag dropped by itself");
  mf_hold_a:
    assert property (mf_request_out && !mf_request_clr_in
      |=> mf_request_out)
    else $error("request flag dropped by itself");
  flag_pair_a:
    assert property ($rose(store_write_done_flag_out) |-> mf_request_out)
    else $error("flags not raised together");
endmodule

bind nvb_ctrl nvb_ctrl_asserts u_nvb_ctrl_asserts (.sys_clk_in,
  .rst_b_in, .req_in, .rdata_out, .done_flag_clr_in,
  .store_write_done_flag_out, .mf_request_out, .mf_request_clr_in);

// ==== bench/tb.sv ====
// Self-checking bench for the store access controller
module tb
  import nvb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WC = 8;
  localparam int RC = 4;
  logic        sys_clk_in = 0;
  logic        rst_b_in = 0;
  nvb_req_type req_in = '0;
  logic        done_clr = 0;
  logic        mf_clr = 0;
  logic [7:0]  rdata_out;
  logic        flag, mf;
  logic        pend = 0;
  logic [7:0]  expq[$];
  logic [7:0]  a, d;
  int          err_total = 0;
  int          samples_checked = 0;
  int          seed = 95480;
  int          n;
  // ==========================================================
  // Clock and design
  always #12.5 sys_clk_in = ~sys_clk_in;
  nvb_ctrl #(.WRITE_CYCLES(WC), .READ_CYCLES(RC)) u_nvb_ctrl (
    .sys_clk_in, .rst_b_in, .req_in, .rdata_out,
    .done_flag_clr_in(done_clr), .store_write_done_flag_out(flag),
    .mf_request_out(mf), .mf_request_clr_in(mf_clr));
  // ==========================================================
  // Tasks
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One bus cycle per call, changed at the falling edge
  task automatic op(logic w, logic r, logic [7:0] ad, logic [7:0] dt);
    @(negedge sys_clk_in);
    req_in = '{w, r, ad, dt};
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    op(0, 1, ad, 8'h00);
    expq.push_back(e);
  endtask
  task automatic idle(int k);
    repeat (k) op(0, 0, 8'h00, 8'h00);
  endtask
  // Answer stands one cycle after the read strobe
  always @(posedge sys_clk_in) begin
    if (pend) chk("rdata", rdata_out, expq.pop_front());
    pend <= req_in.rd;
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_b_in = 1;
    rd(8'h3e, 8'h00);
    rd(8'h3f, 8'h00);
    rd(8'h02, 8'h00);
    op(1, 0, 8'h03, 8'h40);
    // Control writes only land in bank 1
    for (int b = 0; b < 4; b++) begin
      op(1, 0, 8'h04, b[7:0]);
      op(1, 0, 8'h02, 8'h02);
      op(1, 0, 8'h04, 8'h01);
      rd(8'h02, b == 1 ? 8'h02 : 8'h00);
      op(1, 0, 8'h02, 8'h00);
    end
    op(1, 0, 8'h02, 8'hf2);
    rd(8'h02, 8'h02);
    a = 8'($random(seed)) & 8'h3f;
    d = 8'($random(seed));
    op(1, 0, 8'h3e, a | 8'hc0);
    rd(8'h3e, a);
    op(1, 0, 8'h3f, d);
    // Start without permission is ignored
    op(1, 0, 8'h02, 8'h04);
    rd(8'h02, 8'h00);
    idle(WC + 2);
    chk("flag", {7'h00, flag}, 8'h00);
    // Permission first, start in the very next write
    op(1, 0, 8'h02, 8'h08);
    op(1, 0, 8'h02, 8'h0c);
    rd(8'h02, 8'h0c);
    n = 0;
    while (flag !== 1'b1 && n < 4 * WC) begin
      idle(1);
      n++;
    end
    if (flag !== 1'b1) begin
      // Write never ended: counted as a mismatch
      err_total++;
    end else begin
      chk("mf", {7'h00, mf}, 8'h01);
      rd(8'h02, 8'h08);
      // Read strobe drops at the same falling edge as the clears rise
      idle(1);
      done_clr = 1;
      mf_clr = 1;
      idle(1);
      done_clr = 0;
      mf_clr = 0;
      chk("flag", {7'h00, flag}, 8'h00);
      chk("mf", {7'h00, mf}, 8'h00);
      op(1, 0, 8'h3f, ~d);
      rd(8'h3f, ~d);
      // Read start without permission leaves data alone
      op(1, 0, 8'h02, 8'h01);
      rd(8'h02, 8'h00);
      idle(RC + 2);
      rd(8'h3f, ~d);
      // Read permission first, then read start; stored byte replaces data
      op(1, 0, 8'h02, 8'h02);
      op(1, 0, 8'h02, 8'h03);
      rd(8'h02, 8'h03);
      idle(RC + 2);
      rd(8'h02, 8'h02);
      rd(8'h3f, d);
      rd(8'h10, 8'h00);
    end
    idle(3);
    conclude();
  end
endmodule
